// ===== prio_pkg.sv
// constants, offsets and field positions for the priority and trap status block
package prio_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] CORE_CTRL_OFS = 4'h0; // core control word
  localparam logic [3:0] TRAP_CTRL_OFS = 4'h4; // trap status and control word
  localparam logic [3:0] PRIO_LOW_OFS = 4'h8; // lower priority bits word
  localparam logic [3:0] IRQ_MASK_OFS = 4'hC; // interrupt mask word
  // core control field positions
  localparam int PRIO_MSB_BIT = 3; // priority top bit
  localparam int PSV_BIT = 2; // program space view bit
  // trap status field positions
  localparam int NEST_DIS_BIT = 15; // nesting disable control
  localparam int MATH_BIT = 4; // math fault flag
  localparam int ADDR_BIT = 3; // address fault flag
  localparam int STACK_BIT = 2; // stack fault flag
  localparam int OSC_BIT = 1; // oscillator fault flag
  localparam int TRAP_LO_BIT = 1; // lowest trap flag position
  localparam int NUM_TRAPS = 4; // count of trap flags
  // reset values
  localparam logic PSV_RESET = 1'b1; // program space view resets set
  localparam logic [2:0] PRIO_LOW_RESET = 3'h0; // lower level bits at reset
  localparam logic [3:0] PRIO_THRESHOLD = 4'h7; // levels above this block users
  localparam logic [15:0] ZERO16 = 16'h0000; // all clear word
  localparam logic [31:0] ZERO32 = 32'h00000000; // all clear bus word
  // bus handshake states
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// ===== trap_flags.sv
// sticky trap flags, set by trap events and cleared by a one write
`timescale 1ns/10ps
module trap_flags
  import prio_pkg::*;
(
  input wire logic clk_i, // cpu clock
  input wire logic rst_i, // sync reset, active high
  input wire logic [NUM_TRAPS-1:0] event_i, // trap event pulses
  input wire logic [NUM_TRAPS-1:0] clear_i, // one-to-clear pulses
  output logic [NUM_TRAPS-1:0] flags_o // sticky flag state
);
  logic [NUM_TRAPS-1:0] flag_d; // next flag values
  logic [NUM_TRAPS-1:0] flag_q; // held flags

  // per-flag next value; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < NUM_TRAPS; g = g + 1) begin : g_flag
      always_comb begin
        flag_d[g] = flag_q[g];
        if (clear_i[g]) begin
          flag_d[g] = 1'b0;
        end
        if (event_i[g]) begin
          flag_d[g] = 1'b1;
        end
      end
    end
  endgenerate

  // register the flags, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flags_o = flag_q;

  sticky_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q != '0 && clear_i == '0) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("trap flag dropped without a clear");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    event_i[0] |=> flag_q[0])
    else $error("trap event lost");
endmodule

// ===== prio_level.sv
// cpu priority level assembly and user interrupt gating
`timescale 1ns/10ps
module prio_level
  import prio_pkg::*;
(
  input wire logic prio_msb_i, // priority top bit
  input wire logic [2:0] prio_low_i, // lower priority bits
  input wire logic user_req_i, // user interrupt request
  input wire logic trap_req_i, // trap-level request
  output logic [3:0] level_o, // combined priority level
  output logic above7_o, // level exceeds seven
  output logic pass_o // request let through
);
  // combine the level and gate requests
  always_comb begin
    level_o = {prio_msb_i, prio_low_i};
    above7_o = (level_o > PRIO_THRESHOLD);
    // with the top bit set only traps pass
    pass_o = trap_req_i | (user_req_i & ~prio_msb_i);
  end
endmodule

// ===== cpu_priority_trap_status.sv
// cpu priority level, core control and trap status registers on classic wishbone
//
// Notes on behaviour
// - core bit 3 reports level above seven
// - level is top bit over three low
// - top bit set blocks all user interrupts
// - core bit 2 read/write, resets one
// - other core bits read zero, writes ignored
// - math fault flag at bit 4, resets zero
// - nesting disable held at trap bit 15
// - nesting disabled makes low level read-only
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module cpu_priority_trap_status
  import prio_pkg::*;
(
  input wire logic clk_i, // cpu clock, 20 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic prio_msb_set_i, // core raises level to trap range
  input wire logic math_trap_i, // math error trap event
  input wire logic addr_trap_i, // address error trap event
  input wire logic stack_trap_i, // stack error trap event
  input wire logic osc_trap_i, // oscillator failure event
  input wire logic user_req_i, // user interrupt request
  input wire logic trap_req_i, // trap-level request
  output logic [3:0] cpu_priority_level_o, // combined priority level
  output logic int_pass_o, // request accepted by level gate
  output logic nesting_disable_o, // nesting disable control
  output logic irq_o // unmasked trap flag pending
);
  // bus handshake state
  bus_state_t bus_q, bus_d; // ack state
  logic [31:0] rdat_q, rdat_d; // registered read data
  // software visible state
  logic prio_msb_q, prio_msb_d; // priority top bit
  logic psv_q, psv_d; // program space view bit
  logic nest_q, nest_d; // nesting disable
  logic [2:0] prio_low_q, prio_low_d; // lower level bits
  logic [NUM_TRAPS-1:0] mask_q, mask_d; // interrupt mask
  // registered outputs
  logic [3:0] level_q, level_d; // level output
  logic pass_q, pass_d; // gate output
  logic irq_q, irq_d; // interrupt output
  // helper wires
  logic wr_en; // write takes effect now
  logic rd_en; // read taken now
  logic lo_byte; // low byte lane selected
  logic hi_byte; // second byte lane selected
  logic [NUM_TRAPS-1:0] trap_ev; // trap events, bit 0 is oscillator
  logic [NUM_TRAPS-1:0] trap_clr; // one-to-clear pulses
  logic [NUM_TRAPS-1:0] trap_flags; // sticky flags
  logic [3:0] level_w; // combined level
  logic above7_w; // level over seven
  logic pass_w; // gate result
  logic [15:0] core_word; // core control read view
  logic [15:0] trap_word; // trap register read view

  // writes land on the edge where the master samples ack, so a master
  // that drops the cycle before the answer leaves the registers untouched
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & (bus_q == BUS_ACK);
  // reads are taken one cycle earlier so the data stands with ack
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & (bus_q == BUS_IDLE);
  assign lo_byte = wb_sel_i[0];
  assign hi_byte = wb_sel_i[1];
  // bus bit order puts oscillator lowest
  assign trap_ev = {math_trap_i, addr_trap_i, stack_trap_i, osc_trap_i};

  // clear pulses from a one write to the trap word
  always_comb begin
    trap_clr = '0;
    if (wr_en && wb_adr_i == TRAP_CTRL_OFS && lo_byte) begin
      trap_clr = wb_dat_i[TRAP_LO_BIT +: NUM_TRAPS];
    end
  end

  // sticky flags sit in their own module so the set-wins order lives in one place
  trap_flags u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(trap_ev),
    .clear_i(trap_clr),
    .flags_o(trap_flags)
  );

  // level join and gate are pure logic; their results are registered below
  prio_level u_level (
    .prio_msb_i(prio_msb_q),
    .prio_low_i(prio_low_q),
    .user_req_i(user_req_i),
    .trap_req_i(trap_req_i),
    .level_o(level_w),
    .above7_o(above7_w),
    .pass_o(pass_w)
  );

  // read views; unimplemented bits stay zero
  always_comb begin
    core_word = ZERO16;
    core_word[PRIO_MSB_BIT] = above7_w;
    core_word[PSV_BIT] = psv_q;
    trap_word = ZERO16;
    trap_word[NEST_DIS_BIT] = nest_q;
    trap_word[TRAP_LO_BIT +: NUM_TRAPS] = trap_flags;
  end

  // next state of the software registers
  always_comb begin
    prio_msb_d = prio_msb_q;
    psv_d = psv_q;
    nest_d = nest_q;
    prio_low_d = prio_low_q;
    mask_d = mask_q;
    // top bit is raised by the core, software may only clear it
    if (wr_en && wb_adr_i == CORE_CTRL_OFS && lo_byte) begin
      psv_d = wb_dat_i[PSV_BIT];
      if (wb_dat_i[PRIO_MSB_BIT]) begin
        prio_msb_d = 1'b0;
      end
    end
    // a core raise in the same cycle wins over the clear
    if (prio_msb_set_i) begin
      prio_msb_d = 1'b1;
    end
    if (wr_en && wb_adr_i == TRAP_CTRL_OFS && hi_byte) begin
      nest_d = wb_dat_i[NEST_DIS_BIT];
    end
    // low level bits locked while nesting is disabled
    if (wr_en && wb_adr_i == PRIO_LOW_OFS && lo_byte && !nest_q) begin
      prio_low_d = wb_dat_i[2:0];
    end
    if (wr_en && wb_adr_i == IRQ_MASK_OFS && lo_byte) begin
      mask_d = wb_dat_i[TRAP_LO_BIT +: NUM_TRAPS];
    end
  end

  // bus answer: ack one cycle after the request, then drop
  // a strobe held past the ack would be answered again two cycles later
  always_comb begin
    bus_d = BUS_IDLE;
    rdat_d = rdat_q;
    if (wb_cyc_i && wb_stb_i && bus_q == BUS_IDLE) begin
      bus_d = BUS_ACK;
    end
    if (rd_en) begin
      case (wb_adr_i)
        CORE_CTRL_OFS: rdat_d = {ZERO16, core_word};
        TRAP_CTRL_OFS: rdat_d = {ZERO16, trap_word};
        PRIO_LOW_OFS: rdat_d = {ZERO32[31:3], prio_low_q};
        IRQ_MASK_OFS: rdat_d = {ZERO32[31:5], mask_q, 1'b0};
        // unmapped words read zero and still ack
        default: rdat_d = ZERO32;
      endcase
    end
  end

  // output registers
  // irq is a level: it stays high until software clears the flag or the mask
  // the registered copies cost one cycle of latency but keep outputs glitch free
  always_comb begin
    level_d = level_w;
    pass_d = pass_w;
    irq_d = |(trap_flags & mask_q);
  end

  // register everything; reset to documented values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      rdat_q <= ZERO32;
      prio_msb_q <= 1'b0;
      psv_q <= PSV_RESET;
      nest_q <= 1'b0;
      prio_low_q <= PRIO_LOW_RESET;
      mask_q <= '0;
      level_q <= 4'h0;
      pass_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      rdat_q <= rdat_d;
      prio_msb_q <= prio_msb_d;
      psv_q <= psv_d;
      nest_q <= nest_d;
      prio_low_q <= prio_low_d;
      mask_q <= mask_d;
      level_q <= level_d;
      pass_q <= pass_d;
      irq_q <= irq_d;
    end
  end

  assign wb_ack_o = (bus_q == BUS_ACK);
  assign wb_dat_o = rdat_q;
  assign cpu_priority_level_o = level_q;
  assign int_pass_o = pass_q;
  assign nesting_disable_o = nest_q;
  assign irq_o = irq_q;

  // level status bit follows the top priority bit
  above_seven_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_word[PRIO_MSB_BIT] == prio_msb_q)
    else $error("level status bit wrong");

  // a one written to the status bit clears the top bit unless a raise comes
  msb_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == CORE_CTRL_OFS && lo_byte && wb_dat_i[PRIO_MSB_BIT] && !prio_msb_set_i) |=> !prio_msb_q)
    else $error("top priority bit not cleared");

  // registered level is the top bit over the low bits
  level_join_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> cpu_priority_level_o == {$past(prio_msb_q), $past(prio_low_q)})
    else $error("priority level not joined");

  // a user request alone never passes at trap level
  user_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (prio_msb_q && user_req_i && !trap_req_i) |=> !int_pass_o)
    else $error("user interrupt passed at trap level");

  // user requests pass below trap level
  user_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!prio_msb_q && user_req_i) |=> int_pass_o)
    else $error("user interrupt blocked below trap level");

  // trap-level requests always pass
  trap_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_req_i |=> int_pass_o)
    else $error("trap request blocked");

  // trap entry raises the top bit
  msb_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prio_msb_set_i |=> prio_msb_q)
    else $error("top priority bit not raised");

  // program space view takes the written value
  psv_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == CORE_CTRL_OFS && lo_byte) |=> psv_q == $past(wb_dat_i[PSV_BIT]))
    else $error("program space view not written");

  // program space view only moves on a core write
  psv_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_en && wb_adr_i == CORE_CTRL_OFS && lo_byte) |=> $stable(psv_q))
    else $error("program space view changed without a write");

  // core reads show nothing outside the two implemented bits
  core_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en && wb_adr_i == CORE_CTRL_OFS) |=>
    (wb_dat_o & ~((32'h1 << PRIO_MSB_BIT) | (32'h1 << PSV_BIT))) == ZERO32)
    else $error("reserved core bits not zero");

  // a math trap shows in the trap word next cycle
  math_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    math_trap_i |=> trap_word[MATH_BIT])
    else $error("math fault flag not set");

  // oscillator flag holds until a one is written to it
  osc_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (trap_word[OSC_BIT] && !trap_clr[0]) |=> trap_word[OSC_BIT])
    else $error("oscillator flag lost");

  // a clear with no event in the same cycle empties the flag
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (trap_clr[0] && !osc_trap_i) |=> !trap_word[OSC_BIT])
    else $error("oscillator flag not cleared");

  // interrupt is the registered or of unmasked flags
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> irq_o == (|($past(trap_flags) & $past(mask_q))))
    else $error("interrupt level wrong");

  // nesting disable takes the written value
  nest_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == TRAP_CTRL_OFS && hi_byte) |=> nest_q == $past(wb_dat_i[NEST_DIS_BIT]))
    else $error("nesting disable not written");

  // low level bits frozen while nesting is disabled
  low_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    nest_q |=> $stable(prio_low_q))
    else $error("low level changed while locked");

  // low level bits take a write while nesting is enabled
  low_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == PRIO_LOW_OFS && lo_byte && !nest_q) |=> prio_low_q == $past(wb_dat_i[2:0]))
    else $error("low level not written");

  // mask register takes the written value
  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == IRQ_MASK_OFS && lo_byte) |=> mask_q == $past(wb_dat_i[TRAP_LO_BIT +: NUM_TRAPS]))
    else $error("interrupt mask not written");

  // every accepted request is answered next cycle
  ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && bus_q == BUS_IDLE) |=> wb_ack_o)
    else $error("bus request not answered");

  // ack is a single-cycle pulse
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held too long");
endmodule

// ===== cpu_priority_trap_status_tb_top.sv
// self-checking bench for the priority level and trap status block
`timescale 1ns/10ps
module cpu_priority_trap_status_tb_top;
  import prio_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i; // bus and clock drives
  logic [3:0] wb_adr_i, wb_sel_i; // address and lanes
  logic [31:0] wb_dat_i, wb_dat_o; // bus data both ways
  logic wb_ack_o, prio_msb_set_i, user_req_i, trap_req_i; // handshake and requests
  logic [3:0] trap_v; // trap pulses, bit0 osc up to bit3 math
  logic [3:0] cpu_priority_level_o; // level seen
  logic int_pass_o, nesting_disable_o, irq_o; // gate, nesting, interrupt
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic [31:0] v; // random scratch
  int mismatches = 0; // failed comparisons
  int num_checks = 0; // comparisons made
  int seed = 1; // fixed random seed

  cpu_priority_trap_status DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .prio_msb_set_i(prio_msb_set_i), .math_trap_i(trap_v[3]), .addr_trap_i(trap_v[2]),
    .stack_trap_i(trap_v[1]), .osc_trap_i(trap_v[0]), .user_req_i(user_req_i), .trap_req_i(trap_req_i),
    .cpu_priority_level_o(cpu_priority_level_o), .int_pass_o(int_pass_o),
    .nesting_disable_o(nesting_disable_o), .irq_o(irq_o));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    // the previous ack must already have dropped
    chk("wb_ack_o", 32'h00000000, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0; // release only after the ack edge
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // reads note their expectation for the watcher below
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h00000000);
  endtask

  // watcher: a read ack retires the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk("wb_dat_o", exp_q.pop_front(), wb_dat_o);
  end

  // sample settled outputs mid-cycle
  task automatic port(input string nm, input logic [3:0] e, input logic [3:0] g);
    chk(nm, {28'h0, e}, {28'h0, g});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    $display("MISMATCH watchdog expected done seen hang");
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, prio_msb_set_i, user_req_i, trap_req_i} = 6'h00;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h00000000;
    trap_v = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and unused core bits
    rd(CORE_CTRL_OFS, 32'h00000004);
    rd(TRAP_CTRL_OFS, 32'h00000000);
    wb(1'b1, CORE_CTRL_OFS, 32'h0000FFF7);
    rd(CORE_CTRL_OFS, 32'h00000004);
    wb(1'b1, CORE_CTRL_OFS, 32'h00000000);
    rd(CORE_CTRL_OFS, 32'h00000000);
    wb(1'b1, CORE_CTRL_OFS, 32'h00000004);
    // writes with both lanes off are ignored
    wb_sel_i <= 4'h0;
    wb(1'b1, CORE_CTRL_OFS, 32'h00000000);
    wb_sel_i <= 4'h3;
    rd(CORE_CTRL_OFS, 32'h00000004);
    $display("test core control done");
    // random low level values feed the combined level
    repeat (6) begin
      v = $random(seed);
      wb(1'b1, PRIO_LOW_OFS, {29'h0, v[2:0]});
      repeat (2) @(negedge clk_i);
      port("level", {1'b0, v[2:0]}, cpu_priority_level_o);
    end
    // trap entry raises the top bit and shuts out user requests
    @(posedge clk_i);
    user_req_i <= 1'b1;
    prio_msb_set_i <= 1'b1;
    @(posedge clk_i);
    prio_msb_set_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    port("level", {1'b1, v[2:0]}, cpu_priority_level_o);
    port("pass", 4'h0, {3'h0, int_pass_o});
    rd(CORE_CTRL_OFS, 32'h0000000C);
    trap_req_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    port("pass", 4'h1, {3'h0, int_pass_o});
    @(posedge clk_i);
    trap_req_i <= 1'b0;
    wb(1'b1, CORE_CTRL_OFS, 32'h0000000C);
    repeat (2) @(negedge clk_i);
    port("pass", 4'h1, {3'h0, int_pass_o});
    rd(CORE_CTRL_OFS, 32'h00000004);
    $display("test priority top bit done");
    // each trap sets its flag; masked off it stays quiet, unmasked it interrupts
    for (int i = 0; i < NUM_TRAPS; i++) begin
      @(posedge clk_i);
      trap_v <= 4'h1 << i;
      @(posedge clk_i);
      trap_v <= 4'h0;
      repeat (2) @(negedge clk_i);
      port("irq", 4'h0, {3'h0, irq_o});
      rd(TRAP_CTRL_OFS, 32'h1 << (i + 1));
      wb(1'b1, IRQ_MASK_OFS, 32'h1 << (i + 1));
      repeat (2) @(negedge clk_i);
      port("irq", 4'h1, {3'h0, irq_o});
      wb(1'b1, TRAP_CTRL_OFS, 32'h1 << (i + 1));
      repeat (2) @(negedge clk_i);
      port("irq", 4'h0, {3'h0, irq_o});
      rd(TRAP_CTRL_OFS, 32'h00000000);
      wb(1'b1, IRQ_MASK_OFS, 32'h00000000);
    end
    $display("test trap flags done");
    // nesting disabled freezes the low level bits
    wb(1'b1, PRIO_LOW_OFS, 32'h00000005);
    wb(1'b1, TRAP_CTRL_OFS, 32'h00008000);
    @(negedge clk_i);
    port("nesting", 4'h1, {3'h0, nesting_disable_o});
    rd(TRAP_CTRL_OFS, 32'h00008000);
    wb(1'b1, PRIO_LOW_OFS, 32'h00000002);
    rd(PRIO_LOW_OFS, 32'h00000005);
    wb(1'b1, TRAP_CTRL_OFS, 32'h00000000);
    wb(1'b1, PRIO_LOW_OFS, 32'h00000002);
    rd(PRIO_LOW_OFS, 32'h00000002);
    $display("test nesting disable done");
    repeat (2) @(posedge clk_i);
    report_and_stop();
  end
endmodule
